// ===== speech_test_pkg.sv
// Shared constants and types of the speech test serial port.
// Assumes a 200 MHz reference clock; all link timing is derived from it.
package speech_test_pkg;
	localparam int REF_CLK_HZ       = 200_000_000;
	localparam int LINK_BIT_RATE_HZ = 104_000;
	localparam int SAMPLE_RATE_HZ   = 8000;
	localparam int WORD_BITS        = 13;
	localparam int FIFO_DEPTH       = 32;
	localparam int BIT_CYCLES       = REF_CLK_HZ / LINK_BIT_RATE_HZ;
	localparam int HALF_LOW_CYCLES  = BIT_CYCLES / 2;
	localparam int HALF_HIGH_CYCLES = BIT_CYCLES - HALF_LOW_CYCLES;
	localparam int SAMPLE_CYCLES    = REF_CLK_HZ / SAMPLE_RATE_HZ;
	localparam int RESET_MIN_MS     = 4;
	localparam int RESET_MIN_CYCLES = (REF_CLK_HZ / 1000) * RESET_MIN_MS;
	localparam int PHASE_W          = 10;
	localparam int BITS_W           = 4;

	localparam logic [PHASE_W-1:0] LOW_LAST   = PHASE_W'(HALF_LOW_CYCLES - 1);
	localparam logic [PHASE_W-1:0] HIGH_LAST  = PHASE_W'(HALF_HIGH_CYCLES - 1);
	localparam logic [BITS_W-1:0]  WORD_COUNT = BITS_W'(WORD_BITS);

	// Values loaded at reset and while the simulator reset pin is low; the clock also idles between words.
	localparam logic LINK_CLK_IDLE = 1'b1;
	localparam logic TX_IDLE       = 1'b0;

	// Test mode is taken from the two control pins; the over-the-air setup is not supported.
	localparam logic MODE_FROM_PINS = 1'b1;

	typedef enum logic [1:0] {mode_normal, mode_downlink, mode_uplink, mode_acoustic} mode_t;
	typedef enum logic [1:0] {st_idle, st_low, st_high} link_state_t;
endpackage

// ===== sample_stream_if.sv
// Valid/ready word stream between the port logic and its sample buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface sample_stream_if #(parameter int WIDTH = 13) ();
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface

// ===== speech_fifo.sv
// Sample FIFO with a registered output stage.
// Assumes DEPTH is a power of two; flush empties it in one cycle.
`timescale 1ns/1ps
module speech_fifo
	import speech_test_pkg::*;
#(
	parameter int WIDTH = WORD_BITS,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic          clk_in,
	input wire logic          reset_n_in,
	input wire logic          flush_in,
	sample_stream_if.sink     fill,
	sample_stream_if.source   drain
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             out_valid;
	logic [WIDTH-1:0] out_data;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic             push;
	logic             load;

	assign fill.ready  = (count < (AW+1)'(DEPTH)) && !flush_in;
	assign drain.valid = out_valid;
	assign drain.data  = out_data;

	always_comb begin
		push           = fill.valid && fill.ready;
		load           = (count != '0) && (!out_valid || drain.ready);
		next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr    = load ? rd_ptr + 1'b1 : rd_ptr;
		next_count     = count + (AW+1)'(push) - (AW+1)'(load);
		next_out_valid = load || (out_valid && !drain.ready);
		next_out_data  = load ? mem[rd_ptr] : out_data;
		if (flush_in) begin
			next_wr_ptr    = '0;
			next_rd_ptr    = '0;
			next_count     = '0;
			next_out_valid = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			out_valid <= next_out_valid;
			out_data  <= next_out_data;
		end
	end

	// Storage has no reset; only words below the count are ever read.
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= fill.data;
		end
	end
endmodule

// ===== speech_test_port.sv
// Handset end of the serial speech test port: clock master, word framing, mode decode.
// Assumes the control, reset and data pins come from the test simulator, asynchronous to ref_clk_in.
`timescale 1ns/1ps

// Behaviour
// - 13-bit samples at 8 kHz cross a duplex serial pair at 104 kbit/s.
// - The handset drives the bit clock, pulsing only when data is needed or ready.
// - Simulator reset pulse resets transcoders in test modes; pulses shorter than 4 ms reset nothing but stop a running test.
// - The reset pin is active low; release is its rise to high.
// - Words are two's complement, most significant bit first.
// - Inputs sampled on rising clock edges, outputs changed on falling edges.
// - The bit clock idles high outside transfers.
// - Control pins: 00 normal, 01 downlink, 10 uplink, 11 acoustic test.
// - Test mode is accepted from the control pins only.
// - After reset release the handset clocks words as samples are needed.
// - Uplink: first falling edge after release requests the first simulator bit.
// - Downlink: first word out comes from samples decoded after release.
// - Release in any test mode resets the speech transcoders at once.
module speech_test_port
	import speech_test_pkg::*;
#(
	parameter int SAMPLE_PERIOD = SAMPLE_CYCLES,
	parameter int RESET_MIN     = RESET_MIN_CYCLES,
	parameter int BUFFER_DEPTH  = FIFO_DEPTH
) (
	input  wire logic                 ref_clk_in,
	input  wire logic                 reset_n_in,
	input  wire logic                 test_ctrl1_in,
	input  wire logic                 test_ctrl2_in,
	input  wire logic                 sim_reset_n_in,
	input  wire logic                 sim_data_in,
	output logic                      link_clk_out,
	output logic                      handset_data_out,
	input  wire logic [WORD_BITS-1:0] dl_sample_in,
	input  wire logic                 dl_valid_in,
	output logic                      dl_ready_out,
	output logic [WORD_BITS-1:0]      ul_sample_out,
	output logic                      ul_valid_out,
	output logic [1:0]                test_mode_out,
	output logic                      test_active_out,
	output logic                      transcoder_reset_out
);
	localparam int FRAME_W = $clog2(SAMPLE_PERIOD);
	localparam int HOLD_W  = $clog2(RESET_MIN + 1);
	localparam logic [FRAME_W-1:0] FRAME_LAST = FRAME_W'(SAMPLE_PERIOD - 1);
	localparam logic [HOLD_W-1:0]  HOLD_FULL  = HOLD_W'(RESET_MIN);

	function automatic mode_t decode_mode(input logic [1:0] ctrl);
		unique case (ctrl)
			2'h0: decode_mode = mode_normal;
			2'h1: decode_mode = mode_downlink;
			2'h2: decode_mode = mode_uplink;
			2'h3: decode_mode = mode_acoustic;
		endcase
	endfunction

	function automatic logic takes_samples(input mode_t m);
		return (m == mode_uplink) || (m == mode_acoustic);
	endfunction

	function automatic logic gives_samples(input mode_t m);
		return (m == mode_downlink) || (m == mode_acoustic);
	endfunction

	// Two-stage synchronisers for every simulator pin.
	logic [1:0] ctrl_meta;
	logic [1:0] ctrl_sync;
	logic       rst_meta;
	logic       rst_sync;
	logic       data_meta;
	logic       data_sync;

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_meta <= 2'h0;
			ctrl_sync <= 2'h0;
			rst_meta  <= 1'b0;
			rst_sync  <= 1'b0;
			data_meta <= 1'b0;
			data_sync <= 1'b0;
		end else begin
			ctrl_meta <= {test_ctrl1_in, test_ctrl2_in};
			ctrl_sync <= ctrl_meta;
			rst_meta  <= sim_reset_n_in;
			rst_sync  <= rst_meta;
			data_meta <= sim_data_in;
			data_sync <= data_meta;
		end
	end

	sample_stream_if #(.WIDTH(WORD_BITS)) dl_fill ();
	sample_stream_if #(.WIDTH(WORD_BITS)) dl_drain ();

	assign dl_fill.valid = dl_valid_in;
	assign dl_fill.data  = dl_sample_in;
	assign dl_ready_out  = dl_fill.ready;

	// Holding the buffer empty while the pin is low drops stale decoded samples.
	speech_fifo #(
		.WIDTH (WORD_BITS),
		.DEPTH (BUFFER_DEPTH)
	) dl_buffer (
		.clk_in     (ref_clk_in),
		.reset_n_in (reset_n_in),
		.flush_in   (!rst_sync),
		.fill       (dl_fill),
		.drain      (dl_drain)
	);

	mode_t                mode;
	link_state_t          state;
	logic                 active;
	logic                 rst_prev;
	logic [HOLD_W-1:0]    hold_cnt;
	logic [FRAME_W-1:0]   frame_cnt;
	logic [PHASE_W-1:0]   phase_cnt;
	logic [BITS_W-1:0]    bits_left;
	logic [WORD_BITS-1:0] tx_shift;
	logic [WORD_BITS-1:0] rx_shift;
	logic                 link_clk;
	logic                 tx_bit;
	logic                 codec_reset;
	logic [WORD_BITS-1:0] ul_sample;
	logic                 ul_valid;

	mode_t                next_mode;
	link_state_t          next_state;
	logic                 next_active;
	logic [HOLD_W-1:0]    next_hold_cnt;
	logic [FRAME_W-1:0]   next_frame_cnt;
	logic [PHASE_W-1:0]   next_phase_cnt;
	logic [BITS_W-1:0]    next_bits_left;
	logic [WORD_BITS-1:0] next_tx_shift;
	logic [WORD_BITS-1:0] next_rx_shift;
	logic                 next_link_clk;
	logic                 next_tx_bit;
	logic                 next_codec_reset;
	logic [WORD_BITS-1:0] next_ul_sample;
	logic                 next_ul_valid;

	logic                 release_edge;
	logic                 held_long;
	logic                 word_start;
	logic                 pop;
	logic [WORD_BITS-1:0] tx_word;

	assign dl_drain.ready = pop;

	always_comb begin
		next_mode        = mode;
		next_state       = state;
		next_active      = active;
		next_hold_cnt    = hold_cnt;
		next_frame_cnt   = frame_cnt;
		next_phase_cnt   = phase_cnt;
		next_bits_left   = bits_left;
		next_tx_shift    = tx_shift;
		next_rx_shift    = rx_shift;
		next_link_clk    = link_clk;
		next_tx_bit      = tx_bit;
		next_codec_reset = 1'b0;
		next_ul_sample   = ul_sample;
		next_ul_valid    = 1'b0;

		release_edge = rst_sync && !rst_prev;
		held_long    = (hold_cnt == HOLD_FULL);
		// A word starts only at a period boundary and only if it carries data.
		word_start   = active && (state == st_idle) && (frame_cnt == '0)
			&& (takes_samples(mode) || (gives_samples(mode) && dl_drain.valid));
		pop          = word_start && gives_samples(mode) && dl_drain.valid;
		tx_word      = pop ? dl_drain.data : '0;

		if (active) begin
			next_frame_cnt = (frame_cnt == FRAME_LAST) ? '0 : frame_cnt + 1'b1;
		end

		unique case (state)
			st_idle: begin
				next_link_clk = LINK_CLK_IDLE;
				if (word_start) begin
					// First falling edge of the word, most significant bit first.
					next_state     = st_low;
					next_link_clk  = 1'b0;
					next_tx_bit    = tx_word[WORD_BITS-1];
					next_tx_shift  = {tx_word[WORD_BITS-2:0], 1'b0};
					next_bits_left = WORD_COUNT;
					next_phase_cnt = '0;
				end
			end
			st_low: begin
				next_phase_cnt = phase_cnt + 1'b1;
				if (phase_cnt == LOW_LAST) begin
					// Sample the simulator's line on the rising edge.
					next_state     = st_high;
					next_link_clk  = 1'b1;
					next_phase_cnt = '0;
					next_rx_shift  = {rx_shift[WORD_BITS-2:0], data_sync};
					next_bits_left = bits_left - 1'b1;
					if (bits_left == BITS_W'(1) && takes_samples(mode)) begin
						next_ul_sample = {rx_shift[WORD_BITS-2:0], data_sync};
						next_ul_valid  = 1'b1;
					end
				end
			end
			st_high: begin
				next_phase_cnt = phase_cnt + 1'b1;
				if (phase_cnt == HIGH_LAST) begin
					next_phase_cnt = '0;
					if (bits_left == '0) begin
						next_state = st_idle;
					end else begin
						next_state    = st_low;
						next_link_clk = 1'b0;
						next_tx_bit   = tx_shift[WORD_BITS-1];
						next_tx_shift = {tx_shift[WORD_BITS-2:0], 1'b0};
					end
				end
			end
		endcase

		if (!rst_sync) begin
			// The pin is low: stop the link at once and time the pulse.
			next_active    = 1'b0;
			next_state     = st_idle;
			next_link_clk  = LINK_CLK_IDLE;
			next_tx_bit    = TX_IDLE;
			next_frame_cnt = '0;
			if (!held_long) begin
				next_hold_cnt = hold_cnt + 1'b1;
			end
		end else begin
			next_hold_cnt = '0;
			if (release_edge && held_long) begin
				// Mode is latched at release, so pin noise during a test changes nothing.
				next_mode        = decode_mode(ctrl_sync);
				next_active      = decode_mode(ctrl_sync) != mode_normal;
				next_codec_reset = decode_mode(ctrl_sync) != mode_normal;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mode        <= mode_normal;
			state       <= st_idle;
			active      <= 1'b0;
			rst_prev    <= 1'b0;
			hold_cnt    <= '0;
			frame_cnt   <= '0;
			phase_cnt   <= '0;
			bits_left   <= '0;
			tx_shift    <= '0;
			rx_shift    <= '0;
			link_clk    <= LINK_CLK_IDLE;
			tx_bit      <= TX_IDLE;
			codec_reset <= 1'b0;
			ul_sample   <= '0;
			ul_valid    <= 1'b0;
		end else begin
			mode        <= next_mode;
			state       <= next_state;
			active      <= next_active;
			rst_prev    <= rst_sync;
			hold_cnt    <= next_hold_cnt;
			frame_cnt   <= next_frame_cnt;
			phase_cnt   <= next_phase_cnt;
			bits_left   <= next_bits_left;
			tx_shift    <= next_tx_shift;
			rx_shift    <= next_rx_shift;
			link_clk    <= next_link_clk;
			tx_bit      <= next_tx_bit;
			codec_reset <= next_codec_reset;
			ul_sample   <= next_ul_sample;
			ul_valid    <= next_ul_valid;
		end
	end

	assign link_clk_out         = link_clk;
	assign handset_data_out     = tx_bit;
	assign ul_sample_out        = ul_sample;
	assign ul_valid_out         = ul_valid;
	assign test_mode_out        = mode;
	assign test_active_out      = active;
	assign transcoder_reset_out = codec_reset;

	// Helper counters read only by the checks below.
	logic [PHASE_W-1:0] low_len;
	logic [BITS_W-1:0]  rise_cnt;

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			low_len  <= '0;
			rise_cnt <= '0;
		end else begin
			low_len  <= link_clk ? '0 : low_len + 1'b1;
			rise_cnt <= word_start ? '0 : rise_cnt + BITS_W'(link_clk && !low_len_zero());
		end
	end

	function automatic logic low_len_zero();
		return low_len == '0;
	endfunction

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	localparam logic [PHASE_W-1:0] LOW_LEN_EXP = PHASE_W'(HALF_LOW_CYCLES);

	sequence s_long_release;
		release_edge && held_long;
	endsequence

	sequence s_one_cycle_reset;
		codec_reset ##1 !codec_reset;
	endsequence

	property p_idle_high;
		(state == st_idle) |-> link_clk_out;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("link clock low while idle");

	property p_clock_only_in_test;
		!active |-> link_clk_out;
	endproperty
	a_clock_only_in_test: assert property (p_clock_only_in_test) else $error("clock pulse outside a test");

	property p_low_half;
		$rose(link_clk_out) && rst_sync |-> (low_len == LOW_LEN_EXP);
	endproperty
	a_low_half: assert property (p_low_half) else $error("wrong low phase length");

	property p_tx_on_fall;
		$changed(handset_data_out) && rst_sync |-> $fell(link_clk_out);
	endproperty
	a_tx_on_fall: assert property (p_tx_on_fall) else $error("data changed off a falling edge");

	property p_msb_first;
		pop && rst_sync |=> !link_clk_out && (handset_data_out == $past(dl_drain.data[WORD_BITS-1]));
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("first bit is not the sign bit");

	property p_thirteen_pulses;
		ul_valid_out |-> $rose(link_clk_out) && (rise_cnt == BITS_W'(WORD_BITS - 1));
	endproperty
	a_thirteen_pulses: assert property (p_thirteen_pulses) else $error("word not thirteen pulses");

	property p_codec_reset;
		s_long_release and (ctrl_sync != 2'h0) |=> s_one_cycle_reset;
	endproperty
	a_codec_reset: assert property (p_codec_reset) else $error("transcoder reset missing at release");

	property p_short_ignored;
		release_edge && !held_long |=> !active && !codec_reset;
	endproperty
	a_short_ignored: assert property (p_short_ignored) else $error("short reset pulse honoured");

	property p_mode_decode;
		s_long_release |=> (test_mode_out == $past(ctrl_sync));
	endproperty
	a_mode_decode: assert property (p_mode_decode) else $error("mode pins decoded wrongly");

	property p_first_fall;
		s_long_release and (ctrl_sync == 2'h2) |-> ##2 $fell(link_clk_out);
	endproperty
	a_first_fall: assert property (p_first_fall) else $error("uplink first falling edge late");
endmodule

// ===== speech_sim_model.sv
// Behavioural test simulator facing the handset end of the speech test port.
// Assumes the handset drives the bit clock; the bench calls set_mode and reset_pulse by hierarchy.
`timescale 1ns/1ps
module speech_sim_model
	import speech_test_pkg::*;
#(
	parameter int SETTLE = 50
) (
	input  wire logic ref_clk_in,
	input  wire logic link_clk_in,
	input  wire logic handset_data_in,
	output logic      test_ctrl1_out,
	output logic      test_ctrl2_out,
	output logic      sim_reset_n_out,
	output logic      sim_data_out
);
	logic [WORD_BITS-1:0] tx_word;
	logic [WORD_BITS-1:0] rx_shift;
	logic [WORD_BITS-1:0] rx_word;
	logic                 tx_bit;
	logic [BITS_W-1:0]    tx_count;
	logic [BITS_W-1:0]    rx_count;
	int                   n_rx;

	initial begin
		test_ctrl1_out  = 1'b0;
		test_ctrl2_out  = 1'b0;
		sim_reset_n_out = 1'b1;
		tx_word         = 13'h0000;
		tx_bit          = 1'b0;
		tx_count        = 4'h0;
		rx_count        = 4'h0;
		n_rx            = 0;
	end

	// Between words the line shows the inverse of the last bit, so a stale sample cannot pass.
	assign sim_data_out = (tx_count == 4'h0 && rx_count == 4'h0) ? ~tx_bit : tx_bit;

	// Each falling edge presents the next bit, most significant first.
	always @(negedge link_clk_in or negedge sim_reset_n_out) begin
		if (!sim_reset_n_out) begin
			tx_count <= 4'h0;
		end else begin
			tx_bit   <= tx_word[4'(WORD_BITS - 1) - tx_count];
			tx_count <= (tx_count == 4'hc) ? 4'h0 : tx_count + 4'h1;
		end
	end

	// Each rising edge samples the handset line.
	always @(posedge link_clk_in or negedge sim_reset_n_out) begin
		if (!sim_reset_n_out) begin
			rx_count <= 4'h0;
			n_rx     <= 0;
		end else begin
			rx_shift <= {rx_shift[WORD_BITS-2:0], handset_data_in};
			rx_count <= (rx_count == 4'hc) ? 4'h0 : rx_count + 4'h1;
			if (rx_count == 4'hc) begin
				rx_word <= {rx_shift[WORD_BITS-2:0], handset_data_in};
				n_rx    <= n_rx + 1;
			end
		end
	end

	task automatic set_mode(input logic [1:0] mode);
		@(posedge ref_clk_in);
		test_ctrl1_out <= mode[1];
		test_ctrl2_out <= mode[0];
		// The long lead before the reset pulse is scaled down to keep the run short.
		repeat (SETTLE) @(posedge ref_clk_in);
	endtask

	// Active-low pulse; its rise is the release.
	task automatic reset_pulse(input int len);
		@(posedge ref_clk_in);
		sim_reset_n_out <= 1'b0;
		repeat (len) @(posedge ref_clk_in);
		sim_reset_n_out <= 1'b1;
	endtask
endmodule

// ===== tb.sv
// Self-checking bench of the speech test port with a behavioural simulator on the link.
// Assumes a shortened minimum reset pulse of 20 cycles; word timing is left at full length.
`timescale 1ns/1ps
module tb;
	import speech_test_pkg::*;
	logic                 ref_clk_in;
	logic                 reset_n_in;
	logic                 test_ctrl1;
	logic                 test_ctrl2;
	logic                 sim_reset_n;
	logic                 sim_data;
	logic                 link_clk_out;
	logic                 handset_data_out;
	logic [WORD_BITS-1:0] dl_sample_in;
	logic                 dl_valid_in;
	logic                 dl_ready_out;
	logic [WORD_BITS-1:0] ul_sample_out;
	logic                 ul_valid_out;
	logic [1:0]           test_mode_out;
	logic                 test_active_out;
	logic                 transcoder_reset_out;
	int                   n_fail;
	int                   n_tests;

	speech_test_port #(.RESET_MIN(20)) speech_test_port_inst (
		.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .test_ctrl1_in(test_ctrl1), .test_ctrl2_in(test_ctrl2),
		.sim_reset_n_in(sim_reset_n), .sim_data_in(sim_data), .link_clk_out(link_clk_out),
		.handset_data_out(handset_data_out), .dl_sample_in(dl_sample_in), .dl_valid_in(dl_valid_in),
		.dl_ready_out(dl_ready_out), .ul_sample_out(ul_sample_out), .ul_valid_out(ul_valid_out),
		.test_mode_out(test_mode_out), .test_active_out(test_active_out),
		.transcoder_reset_out(transcoder_reset_out));

	speech_sim_model speech_sim_model_inst (
		.ref_clk_in(ref_clk_in), .link_clk_in(link_clk_out), .handset_data_in(handset_data_out),
		.test_ctrl1_out(test_ctrl1), .test_ctrl2_out(test_ctrl2), .sim_reset_n_out(sim_reset_n),
		.sim_data_out(sim_data));

	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic timed_out();
		n_fail++;
		$display("[FAIL] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
		end_sim();
	endtask

	// Normal mode never clocks the link and never pulses the transcoder reset.
	task automatic t_idle();
		int bad;
		bad = 0;
		speech_sim_model_inst.set_mode(2'h0);
		speech_sim_model_inst.reset_pulse(30);
		repeat (3000) begin
			@(posedge ref_clk_in);
			#1;
			if (link_clk_out !== 1'b1 || transcoder_reset_out !== 1'b0 || handset_data_out !== 1'b0) bad++;
		end
		check(16'(bad), 16'h0000);
		check(16'(test_active_out), 16'h0000);
	endtask

	// A pulse shorter than the minimum leaves the block inactive.
	task automatic t_short();
		int bad;
		bad = 0;
		speech_sim_model_inst.set_mode(2'h3);
		speech_sim_model_inst.reset_pulse(8);
		repeat (40) begin
			@(posedge ref_clk_in);
			#1;
			if (link_clk_out !== 1'b1 || transcoder_reset_out !== 1'b0) bad++;
		end
		check(16'(bad), 16'h0000);
		check(16'(test_active_out), 16'h0000);
	endtask

	// Every mode code; the reset pulse before mode 3 also cuts short the uplink word in flight.
	task automatic t_modes();
		int pulses;
		int falls;
		for (int m = 0; m < 4; m++) begin
			pulses = 0;
			falls  = 0;
			speech_sim_model_inst.set_mode(2'(m));
			speech_sim_model_inst.reset_pulse(30);
			repeat (8) begin
				@(posedge ref_clk_in);
				#1;
				if (transcoder_reset_out === 1'b1) pulses++;
				if (link_clk_out === 1'b0) falls++;
			end
			check(16'(test_mode_out), 16'(m));
			check(16'(test_active_out), 16'(m != 0));
			check(16'(pulses), 16'(m != 0));
			check(16'(falls > 0), 16'(m >= 2));
		end
	endtask

	// A negative sample from the simulator arrives whole after release.
	task automatic t_uplink();
		int n;
		n = 0;
		speech_sim_model_inst.tx_word = 13'h1a5c;
		speech_sim_model_inst.set_mode(2'h2);
		speech_sim_model_inst.reset_pulse(30);
		while (ul_valid_out !== 1'b1 && n < 30000) begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end
		if (n == 30000) timed_out();
		check(16'(ul_sample_out), 16'h1a5c);
		check(16'(test_mode_out), 16'h0002);
		@(posedge ref_clk_in);
		#1;
		check(16'(ul_valid_out), 16'h0000);
	endtask

	// A word pushed after release reaches the simulator and the clock then rests high.
	task automatic t_downlink();
		int n;
		n = 0;
		speech_sim_model_inst.set_mode(2'h1);
		speech_sim_model_inst.reset_pulse(30);
		@(posedge ref_clk_in);
		dl_sample_in <= 13'h0b3d;
		dl_valid_in  <= 1'b1;
		#1;
		check(16'(dl_ready_out), 16'h0000);
		while (dl_ready_out !== 1'b1 && n < 40) begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end
		if (n == 40) timed_out();
		@(posedge ref_clk_in);
		dl_valid_in <= 1'b0;
		n = 0;
		while (speech_sim_model_inst.n_rx != 1 && n < 60000) begin
			@(posedge ref_clk_in);
			n++;
		end
		if (n == 60000) timed_out();
		check(16'(speech_sim_model_inst.rx_word), 16'h0b3d);
		repeat (2000) @(posedge ref_clk_in);
		#1;
		check(16'(link_clk_out), 16'h0001);
	endtask

	// A system reset in mid-word parks the link at once; the test does not resume without a new pulse.
	task automatic t_sys_reset();
		int bad;
		bad = 0;
		speech_sim_model_inst.set_mode(2'h2);
		speech_sim_model_inst.reset_pulse(30);
		repeat (100) @(posedge ref_clk_in);
		#1;
		check(16'(link_clk_out), 16'h0000);
		@(posedge ref_clk_in);
		reset_n_in <= 1'b0;
		repeat (4) begin
			@(posedge ref_clk_in);
			#1;
			if (link_clk_out !== 1'b1 || handset_data_out !== 1'b0 || dl_ready_out !== 1'b0) bad++;
		end
		check(16'(bad), 16'h0000);
		@(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		repeat (2) begin
			@(posedge ref_clk_in);
			#1;
			check(16'(link_clk_out), 16'h0001);
			check(16'(test_active_out), 16'h0000);
			check(16'(test_mode_out), 16'h0000);
			check(16'(transcoder_reset_out), 16'h0000);
		end
		bad = 0;
		repeat (200) begin
			@(posedge ref_clk_in);
			#1;
			if (link_clk_out !== 1'b1 || test_active_out !== 1'b0) bad++;
		end
		check(16'(bad), 16'h0000);
		check(16'(dl_ready_out), 16'h0001);
	endtask

	initial begin
		n_fail       = 0;
		n_tests      = 0;
		reset_n_in   = 1'b0;
		dl_sample_in = 13'h0000;
		dl_valid_in  = 1'b0;
		repeat (12) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		#1;
		check(16'(link_clk_out), 16'h0001);
		t_idle();
		t_short();
		t_modes();
		t_uplink();
		t_downlink();
		t_sys_reset();
		end_sim();
	end
endmodule
